// *** rtl/idx_seq_pkg.sv ***
// Package: instruction groups, bus cycle kinds, bus pin and request records and constants for the indexed sequencer
`default_nettype none
package idx_seq_pkg;

  // Address driven during idle cycles
  localparam logic [15:0] IDLE_ADDR     = 16'hffff;
  // Data driven by a clear
  localparam logic [7:0]  CLEAR_DATA    = 8'h00;
  // Values after reset
  localparam logic [15:0] RESET_ADDR    = 16'hffff;
  localparam logic [7:0]  RESET_DATA    = 8'h00;
  localparam logic [2:0]  RESET_STEP    = 3'h0;
  // Address increments: plus two and plus three for the next fetch, plus one for the following byte
  localparam logic [15:0] NEXT_PLUS_TWO   = 16'h0002;
  localparam logic [15:0] NEXT_PLUS_THREE = 16'h0003;
  localparam logic [15:0] PLUS_ONE        = 16'h0001;

  // Instruction groups of the indexed mode
  typedef enum logic [3:0] {
    jump_op,
    read8_op,
    accumulator_store_op,
    read16_op,
    store16_op,
    call_op,
    rmw_op,
    test_immediate_op,
    clear_op,
    logic_immediate_memory_op
  } group_t;

  // Kinds of bus cycle
  typedef enum logic [1:0] {
    cyc_read,
    cyc_write,
    cyc_idle
  } cycle_kind_t;

  // Bus pins of one cycle
  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic        rd_n;
    logic        wr_n;
    logic        opcode_fetch_indicator_n;
    logic [7:0]  wdata;
  } bus_t;

  // Instruction request from the core
  typedef struct packed {
    group_t      group;
    logic [15:0] opcode_addr;
    logic [15:0] index_register;
    logic [15:0] stack_pointer;
    logic [15:0] return_addr;
    logic [7:0]  wr_lo;
    logic [7:0]  wr_hi;
  } req_t;

endpackage : idx_seq_pkg
`default_nettype wire

// *** rtl/indexed_mode_bus_cycle_sequencer.sv ***
// Bus-cycle sequencer for indexed-mode instructions of an 8-bit core
`default_nettype none

// What this block does
// RQ1: Indexed jump: offset fetch, idle FFFF, target opcode fetch; three cycles.
// RQ2: Indexed 8-bit reads: offset, idle, operand read, next opcode at plus two.
// RQ3: Accumulator store: third cycle writes accumulator at index plus offset.
// RQ4: 16-bit reads: high byte at effective address, low byte next, fetch plus two.
// RQ5: 16-bit stores: offset, idle, write high, write low, next opcode fetch.
// RQ6: Call: offset, idle, return low at SP, high at SP-1, fetch at target.
// RQ7: Read-modify-write: offset, idle, read, idle, write, fetch; six cycles.
// RQ8: Test immediate: immediate, offset, idle, read, fetch at plus three; no write.
// RQ9: Clear: offset, idle, read, write 00 same address, fetch; five cycles.
// RQ10: Logic immediate to memory: seven cycles, write result, fetch plus three.
// RQ11: Reads 1/0/1, writes 0/1/0 on rw/rd/wr; fetch indicator low on next opcode only.
// RQ12: Effective address is index plus unsigned offset; idle cycles transfer nothing.
module indexed_mode_bus_cycle_sequencer (
  // Clock, reset, enable
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 clock_en,
  // Instruction request
  input  wire logic                 start,
  input  wire idx_seq_pkg::req_t    req,
  output logic                      busy,
  output logic                      done,
  // Data from the core for writes that depend on the operand
  input  wire logic [7:0]           result_data,
  // Processor bus
  input  wire logic [7:0]           rdata,
  output idx_seq_pkg::bus_t         bus,
  // Captured bytes
  output logic [7:0]                imm_byte,
  output logic [7:0]                operand_hi,
  output logic [7:0]                operand_lo
);

  // Whole state record
  typedef struct packed {
    logic                 active;
    logic [2:0]           step;
    idx_seq_pkg::group_t  group;
    logic [15:0]          opcode_addr;
    logic [15:0]          index_register;
    logic [15:0]          stack_pointer;
    logic [15:0]          return_addr;
    logic [7:0]           wr_lo;
    logic [7:0]           wr_hi;
    logic [7:0]           offset;
    logic [7:0]           imm;
    logic [7:0]           op_hi;
    logic [7:0]           op_lo;
    idx_seq_pkg::bus_t    bus;
    logic                 done;
  } state_t;

  state_t st;
  state_t next_st;

  // Effective address, offset unsigned
  logic [15:0] eff_addr;
  logic [15:0] eff_addr_plus1;
  assign eff_addr       = st.index_register + {8'h00, st.offset}; // RQ12
  assign eff_addr_plus1 = eff_addr + idx_seq_pkg::PLUS_ONE;

  // Bus cycle driving helper
  function automatic idx_seq_pkg::bus_t drive(input idx_seq_pkg::cycle_kind_t kind,
                                              input logic [15:0] addr,
                                              input logic [7:0] wdata,
                                              input logic fetch);
    idx_seq_pkg::bus_t b;
    b.addr  = addr;
    b.wdata = wdata;
    b.opcode_fetch_indicator_n = ~fetch; // RQ11
    unique case (kind)
      idx_seq_pkg::cyc_read: begin
        b.rw   = 1'b1; // RQ11
        b.rd_n = 1'b0;
        b.wr_n = 1'b1;
      end
      idx_seq_pkg::cyc_write: begin
        b.rw   = 1'b0; // RQ11
        b.rd_n = 1'b1;
        b.wr_n = 1'b0;
      end
      default: begin
        b.addr = idx_seq_pkg::IDLE_ADDR; // RQ12
        b.rw   = 1'b1;
        b.rd_n = 1'b1;
        b.wr_n = 1'b1;
        b.opcode_fetch_indicator_n = 1'b1;
      end
    endcase
    return b;
  endfunction : drive

  // Next state: each step sets the bus for the coming cycle
  always_comb begin
    logic        has_imm;
    logic [2:0]  s;
    logic [2:0]  r;
    logic [15:0] fetch_addr;
    has_imm      = (st.group == idx_seq_pkg::test_immediate_op) ||
                   (st.group == idx_seq_pkg::logic_immediate_memory_op);
    s            = st.step;
    r            = has_imm ? s - 3'h1 : s;
    fetch_addr   = st.opcode_addr + (has_imm ? idx_seq_pkg::NEXT_PLUS_THREE : idx_seq_pkg::NEXT_PLUS_TWO);
    next_st      = st;
    next_st.done = 1'b0;
    if (!st.active) begin
      next_st.bus = drive(idx_seq_pkg::cyc_idle, idx_seq_pkg::IDLE_ADDR, idx_seq_pkg::RESET_DATA, 1'b0);
      if (start) begin
        next_st.active         = 1'b1;
        next_st.step           = idx_seq_pkg::RESET_STEP;
        next_st.group          = req.group;
        next_st.opcode_addr    = req.opcode_addr;
        next_st.index_register = req.index_register;
        next_st.stack_pointer  = req.stack_pointer;
        next_st.return_addr    = req.return_addr;
        next_st.wr_lo          = req.wr_lo;
        next_st.wr_hi          = req.wr_hi;
        // First cycle always reads at opcode address plus one
        next_st.bus = drive(idx_seq_pkg::cyc_read, req.opcode_addr + idx_seq_pkg::PLUS_ONE,
                            idx_seq_pkg::RESET_DATA, 1'b0);
      end
    end else begin
      next_st.step = s + 3'h1;
      // Capture read data of the cycle now ending
      if (has_imm && s == 3'h0)
        next_st.imm = rdata;
      if ((has_imm && s == 3'h1) || (!has_imm && s == 3'h0))
        next_st.offset = rdata;
      // Immediate groups fetch the offset in their second cycle
      if (has_imm && s == 3'h0) begin
        next_st.bus = drive(idx_seq_pkg::cyc_read, st.opcode_addr + idx_seq_pkg::NEXT_PLUS_TWO,
                            idx_seq_pkg::RESET_DATA, 1'b0); // RQ8 RQ10
      end else if ((has_imm && s == 3'h1) || (!has_imm && s == 3'h0)) begin
        next_st.bus = drive(idx_seq_pkg::cyc_idle, idx_seq_pkg::IDLE_ADDR, idx_seq_pkg::RESET_DATA, 1'b0);
      end else begin
        unique case (st.group)
          idx_seq_pkg::jump_op: begin
            next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ1
            next_st.active = 1'b0;
            next_st.done   = 1'b1;
          end
          idx_seq_pkg::read8_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b0); // RQ2
            end else begin
              next_st.op_lo = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ2
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::accumulator_store_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, eff_addr, st.wr_lo, 1'b0); // RQ3
            end else begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1);
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::read16_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b0); // RQ4
            end else if (s == 3'h2) begin
              next_st.op_hi = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr_plus1, idx_seq_pkg::RESET_DATA, 1'b0); // RQ4
            end else begin
              next_st.op_lo = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ4
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::store16_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, eff_addr, st.wr_hi, 1'b0); // RQ5
            end else if (s == 3'h2) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, eff_addr_plus1, st.wr_lo, 1'b0); // RQ5
            end else begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1);
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::call_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, st.stack_pointer, st.return_addr[7:0], 1'b0); // RQ6
            end else if (s == 3'h2) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, st.stack_pointer - idx_seq_pkg::PLUS_ONE,
                                  st.return_addr[15:8], 1'b0); // RQ6
            end else begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ6
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::clear_op: begin
            if (s == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b0); // RQ9
            end else if (s == 3'h2) begin
              next_st.op_lo = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_write, eff_addr, idx_seq_pkg::CLEAR_DATA, 1'b0); // RQ9
            end else begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1);
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          idx_seq_pkg::test_immediate_op: begin
            if (s == 3'h2) begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b0); // RQ8
            end else begin
              next_st.op_lo = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ8
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
          default: begin
            // Read-modify-write and logic-immediate share one tail; the latter is one step later
            if (r == 3'h1) begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, eff_addr, idx_seq_pkg::RESET_DATA, 1'b0); // RQ7 RQ10
            end else if (r == 3'h2) begin
              next_st.op_lo = rdata;
              next_st.bus = drive(idx_seq_pkg::cyc_idle, idx_seq_pkg::IDLE_ADDR, idx_seq_pkg::RESET_DATA, 1'b0);
            end else if (r == 3'h3) begin
              next_st.bus = drive(idx_seq_pkg::cyc_write, eff_addr, result_data, 1'b0); // RQ7 RQ10
            end else begin
              next_st.bus = drive(idx_seq_pkg::cyc_read, fetch_addr, idx_seq_pkg::RESET_DATA, 1'b1); // RQ7 RQ10
              next_st.active = 1'b0;
              next_st.done   = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st       <= '0;
      st.bus   <= '{addr: idx_seq_pkg::RESET_ADDR, rw: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    opcode_fetch_indicator_n: 1'b1, wdata: idx_seq_pkg::RESET_DATA};
    end else if (clock_en) begin
      st <= next_st;
    end
  end

  // Outputs
  assign bus        = st.bus;
  assign busy       = st.active;
  assign done       = st.done;
  assign imm_byte   = st.imm;
  assign operand_hi = st.op_hi;
  assign operand_lo = st.op_lo;

  // Strobe encoding consistency
  strobe_code_a: assert property (@(posedge clock) disable iff (rst) // RQ11
    (bus.rw == bus.wr_n) && !(bus.rd_n == 1'b0 && bus.wr_n == 1'b0))
    else $error("read and write strobes inconsistent");
  // A cycle with no strobe is at the idle address
  idle_quiet_a: assert property (@(posedge clock) disable iff (rst) // RQ12
    (bus.rd_n && bus.wr_n) |-> bus.addr == idx_seq_pkg::IDLE_ADDR)
    else $error("transfer-free cycle not at idle address");
  // Fetch only as a read
  fetch_read_a: assert property (@(posedge clock) disable iff (rst) // RQ11
    !bus.opcode_fetch_indicator_n |-> (!bus.rd_n && bus.rw && done))
    else $error("fetch indicator outside final read");
  // Jump lasts three cycles
  jump_len_a: assert property (@(posedge clock) disable iff (rst || !clock_en) // RQ1
    (start && !busy && req.group == idx_seq_pkg::jump_op) |=> busy ##1 busy ##1 done)
    else $error("jump length wrong");
  // Eight-bit read lasts four cycles
  read8_len_a: assert property (@(posedge clock) disable iff (rst || !clock_en) // RQ2
    (start && !busy && req.group == idx_seq_pkg::read8_op) |=> busy[*3] ##1 done)
    else $error("read length wrong");
  // Store writes in third cycle
  store_write_a: assert property (@(posedge clock) disable iff (rst || !clock_en) // RQ3
    (start && !busy && req.group == idx_seq_pkg::accumulator_store_op) |=> ##2 (!bus.wr_n && !bus.rw))
    else $error("store write cycle misplaced");
  // Second idle in read-modify-write
  rmw_idle_a: assert property (@(posedge clock) disable iff (rst || !clock_en) // RQ7
    (start && !busy && req.group == idx_seq_pkg::rmw_op) |=> ##3 (bus.addr == idx_seq_pkg::IDLE_ADDR) ##1 !bus.wr_n)
    else $error("read-modify-write sequence wrong");
  // Clear writes zero
  clear_zero_a: assert property (@(posedge clock) disable iff (rst || !clock_en) // RQ9
    (start && !busy && req.group == idx_seq_pkg::clear_op) |=> ##3 (!bus.wr_n && bus.wdata == idx_seq_pkg::CLEAR_DATA))
    else $error("clear did not write zero");

endmodule : indexed_mode_bus_cycle_sequencer
`default_nettype wire

// *** test/bus_memory_model.sv ***
// Memory and peripheral model answering the sequencer's bus cycles
`default_nettype none
module bus_memory_model (
  // Clock
  input  wire logic              clock,
  // Bus from the sequencer and read data back
  input  wire idx_seq_pkg::bus_t bus,
  output logic [7:0]             rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_data = 8'h00;
  // Contents are a pattern of the address; a released bus shows the inverted last byte
  always_comb begin
    if (!bus.rd_n) begin
      rdata = bus.addr[7:0] ^ bus.addr[15:8];
    end else begin
      rdata = ~last_data;
    end
  end
  // Remember the last byte that memory drove, so a released bus stays the inverse of it
  always @(posedge clock) begin
    if (!bus.rd_n) begin
      last_data <= rdata;
    end
  end
endmodule : bus_memory_model
`default_nettype wire

// *** test/indexed_mode_bus_cycle_sequencer_bench.sv ***
// Self-checking bench for the indexed-mode bus-cycle sequencer
`default_nettype none
module indexed_mode_bus_cycle_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] K_READ  = 2'h0;
  localparam logic [1:0] K_WRITE = 2'h1;
  localparam logic [1:0] K_IDLE  = 2'h2;
  localparam logic [1:0] K_FETCH = 2'h3;
  logic              clock = 1'b0;
  logic              rst, clock_en, start, busy, done;
  logic [7:0]        result_data, rdata, imm_byte, operand_hi, operand_lo;
  idx_seq_pkg::req_t req, cur;
  idx_seq_pkg::bus_t bus;
  logic [1:0]        ek [8];
  logic [15:0]       eaddr [8];
  logic [7:0]        ed [8];
  logic [15:0]       eff;
  int                en, failures, samples_checked, seed;

  indexed_mode_bus_cycle_sequencer dut_u (
    .clock(clock), .rst(rst), .clock_en(clock_en), .start(start), .req(req), .busy(busy),
    .done(done), .result_data(result_data), .rdata(rdata), .bus(bus), .imm_byte(imm_byte),
    .operand_hi(operand_hi), .operand_lo(operand_lo));
  bus_memory_model mem_u (.clock(clock), .bus(bus), .rdata(rdata));

  // Clock at 25 MHz
  always #20 clock = ~clock;

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : mem_byte

  // Expected pins: addr, rw, rd_n, wr_n, fetch indicator, done, busy
  function automatic logic [23:0] exp_vec(input logic [1:0] k, input logic [15:0] a, input logic b);
    return {2'h0, (k == K_IDLE) ? 16'hffff : a, k != K_WRITE, k inside {K_WRITE, K_IDLE},
            k != K_WRITE, k != K_FETCH, k == K_FETCH, b};
  endfunction : exp_vec

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic check_cycle(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d, input logic b);
    chk("cycle", exp_vec(k, a, b), {2'h0, bus.addr, bus.rw, bus.rd_n, bus.wr_n,
        bus.opcode_fetch_indicator_n, done, busy});
    if (k == K_WRITE) chk("wdata", {16'h0, d}, {16'h0, bus.wdata});
  endtask : check_cycle

  task automatic add(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    ek[en] = k;
    eaddr[en] = a;
    ed[en] = d;
    en++;
  endtask : add

  // Expected cycle list of one instruction
  task automatic build(input idx_seq_pkg::req_t r, input logic [7:0] res);
    logic [15:0] op;
    logic [15:0] two;
    logic        tail;
    op = r.opcode_addr;
    two = (r.group inside {idx_seq_pkg::test_immediate_op, idx_seq_pkg::logic_immediate_memory_op}) ?
          16'h0001 : 16'h0000;
    tail = r.group inside {idx_seq_pkg::rmw_op, idx_seq_pkg::logic_immediate_memory_op};
    eff = r.index_register + {8'h00, mem_byte(op + 16'h0001 + two)};
    en = 0;
    add(K_READ, op + 16'h0001, 8'h00);
    if (two[0]) add(K_READ, op + 16'h0002, 8'h00);
    add(K_IDLE, 16'hffff, 8'h00);
    if (r.group inside {idx_seq_pkg::read8_op, idx_seq_pkg::read16_op, idx_seq_pkg::clear_op,
        idx_seq_pkg::test_immediate_op} || tail) add(K_READ, eff, 8'h00);
    if (r.group == idx_seq_pkg::read16_op) add(K_READ, eff + 16'h0001, 8'h00);
    if (tail) add(K_IDLE, 16'hffff, 8'h00);
    if (tail) add(K_WRITE, eff, res);
    if (r.group == idx_seq_pkg::clear_op) add(K_WRITE, eff, 8'h00);
    if (r.group == idx_seq_pkg::accumulator_store_op) add(K_WRITE, eff, r.wr_lo);
    if (r.group == idx_seq_pkg::store16_op) add(K_WRITE, eff, r.wr_hi);
    if (r.group == idx_seq_pkg::store16_op) add(K_WRITE, eff + 16'h0001, r.wr_lo);
    if (r.group == idx_seq_pkg::call_op) add(K_WRITE, r.stack_pointer, r.return_addr[7:0]);
    if (r.group == idx_seq_pkg::call_op) add(K_WRITE, r.stack_pointer - 16'h0001, r.return_addr[15:8]);
    if (r.group inside {idx_seq_pkg::jump_op, idx_seq_pkg::call_op}) add(K_FETCH, eff, 8'h00);
    else add(K_FETCH, op + 16'h0002 + two, 8'h00);
  endtask : build

  // Issue one instruction; hold keeps start high while busy, stall freezes with clock_en
  task automatic run(input idx_seq_pkg::req_t r, input logic [7:0] res, input bit hold, input bit stall);
    build(r, res);
    start = 1'b1;
    req = r;
    result_data = res;
    for (int i = 0; i < en; i++) begin
      @(negedge clock);
      check_cycle(ek[i], eaddr[i], ed[i], i < en - 1);
      if (i < en - 1) begin
        start = hold;
        if (hold) req.opcode_addr = 16'($urandom);
        if (stall) begin
          clock_en = 1'b0;
          @(negedge clock);
          check_cycle(ek[i], eaddr[i], ed[i], 1'b1);
          clock_en = 1'b1;
        end
      end
    end
    if (r.group == idx_seq_pkg::read16_op) chk("operand", {8'h0, mem_byte(eff), mem_byte(eff + 16'h0001)},
        {8'h0, operand_hi, operand_lo});
    if (r.group inside {idx_seq_pkg::test_immediate_op, idx_seq_pkg::logic_immediate_memory_op})
      chk("imm", {16'h0, mem_byte(r.opcode_addr + 16'h0001)}, {16'h0, imm_byte});
    if (r.group inside {idx_seq_pkg::read8_op, idx_seq_pkg::clear_op, idx_seq_pkg::rmw_op,
        idx_seq_pkg::test_immediate_op, idx_seq_pkg::logic_immediate_memory_op})
      chk("operand_lo", {16'h0, mem_byte(eff)}, {16'h0, operand_lo});
  endtask : run

  task automatic idle_check();
    start = 1'b0;
    @(negedge clock);
    check_cycle(K_IDLE, 16'hffff, 8'h00, 1'b0);
  endtask : idle_check

  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Main sequence: corner cases for every group, then random traffic
  initial begin
    rst = 1'b1;
    clock_en = 1'b1;
    start = 1'b0;
    req = '0;
    result_data = 8'h00;
    failures = 0;
    samples_checked = 0;
    seed = $urandom(32'h78e86926);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    idle_check();
    for (int g = 0; g < 10; g++) begin
      cur = '0;
      cur.group = idx_seq_pkg::group_t'(g);
      cur.opcode_addr = 16'h00fe;
      cur.index_register = 16'hff80;
      cur.return_addr = 16'h1234;
      cur.wr_lo = 8'ha5;
      cur.wr_hi = 8'h5a;
      run(cur, 8'hc3, g[0], g[1]);
    end
    // Reset in mid-sequence must return the bus to its idle values
    start = 1'b1;
    req = cur;
    @(negedge clock);
    check_cycle(K_READ, cur.opcode_addr + 16'h0001, 8'h00, 1'b1);
    start = 1'b0;
    rst = 1'b1;
    @(negedge clock);
    check_cycle(K_IDLE, 16'hffff, 8'h00, 1'b0);
    rst = 1'b0;
    idle_check();
    for (int n = 0; n < 300; n++) begin
      cur.group = idx_seq_pkg::group_t'($urandom % 10);
      cur.opcode_addr = 16'($urandom);
      cur.index_register = 16'($urandom);
      cur.stack_pointer = 16'($urandom);
      cur.return_addr = 16'($urandom);
      cur.wr_lo = 8'($urandom);
      cur.wr_hi = 8'($urandom);
      run(cur, 8'($urandom), ($urandom % 4) == 0, ($urandom % 4) == 0);
      if ($urandom % 3 == 0) idle_check();
    end
    conclude();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    failures++;
    conclude();
  end
endmodule : indexed_mode_bus_cycle_sequencer_bench
`default_nettype wire
